// ---- core/pfb_pkg.sv ----
package pfb_pkg;
  localparam int ADDR_W     = 17;
  localparam int DATA_W     = 8;
  localparam int COL_W      = 3;
  localparam int CLK_MHZ    = 25;
  localparam int T_ACC_NS   = 60;
  localparam int T_RC_NS    = 90;
  localparam int T_PAGE_NS  = 30;
  localparam int T_PC_NS    = 60;
  localparam int ACC_CYC    = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int RC_CYC     = (T_RC_NS * CLK_MHZ + 999) / 1000;
  localparam int PAGE_CYC   = (T_PAGE_NS * CLK_MHZ + 999) / 1000;
  localparam int PC_CYC     = (T_PC_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W      = 4;

  typedef enum logic [4:0] {
    PFB_IDLE  = 5'b0_0001,
    PFB_SEL   = 5'b0_0010,
    PFB_RD    = 5'b0_0100,
    PFB_WR    = 5'b0_1000,
    PFB_PCHG  = 5'b1_0000
  } pfb_state_e;
endpackage : pfb_pkg

// ---- core/pfb_host.sv ----
// Contract
// RQ1: Drive 17-bit address per access
// RQ2: Share one 8-bit two-way data bus
// RQ3: Write strobe low, rising edge stores byte
// RQ4: Each strobe fall carries fresh column address
// RQ5: Select by select_n fall, select_p high
// RQ6: Full address stable at select edge
// RQ7: Device pulls select_p up when undriven
// RQ8: Same row: change only column bits
// RQ9: Device drives data only once valid
// RQ10: Output enable high keeps bus released
// RQ11: Accesses start on select or address
// RQ12: 60 ns access, 90 ns random cycle
// RQ13: Page accesses down to 30 ns
// RQ14: Stored bytes survive power loss
// RQ15: Row is upper bits, column low three
// RQ16: Row change causes internal pre-charge
// RQ17: Hold select inactive for precharge_time
// RQ18: Device never drives while strobe low
// RQ19: Deselected device ignores strobe, releases bus
`timescale 1ns/1ps
`default_nettype none
module pfb_host
  import pfb_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // User request
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_rdata,
  // Memory pins
  output logic [ADDR_W-1:0]      byte_address,
  output logic                   select_n,
  output logic                   select_p,
  output logic                   write_n,
  output logic                   out_en_n,
  input  wire logic [DATA_W-1:0] data_bus_i,
  output logic [DATA_W-1:0]      data_bus_o,
  output logic                   data_bus_oe_n
);
  pfb_state_e              state_reg, state_next;
  logic [CNT_W-1:0]        cnt_reg, cnt_next;
  logic                    write_reg, write_next;
  logic                    rdy_reg, rdy_next;
  logic [ADDR_W-1:0]       addr_reg, addr_next;
  logic [DATA_W-1:0]       wdata_reg, wdata_next;
  logic [DATA_W-1:0]       rdata_reg, rdata_next;
  logic                    rv_reg, rv_next;
  logic                    sel_n_reg, sel_n_next;
  logic                    sel_p_reg, sel_p_next;
  logic                    we_n_reg, we_n_next;
  logic                    oe_n_reg, oe_n_next;
  logic                    doe_n_reg, doe_n_next;
  logic                    take;
  logic                    cnt_zero;

  assign take     = req_valid && rdy_reg;
  assign cnt_zero = cnt_reg == '0;

  // Sequencer: phase, phase timer, direction and ready
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    write_next = write_reg;
    rdy_next   = rdy_reg;
    if (!cnt_zero) begin
      cnt_next = cnt_reg - 1'b1;
    end
    unique case (state_reg)
      PFB_IDLE: begin
        rdy_next = 1'b1;
        if (take) begin
          // Direction kept so the request may drop after the take
          write_next = req_write;
          rdy_next   = 1'b0;
          state_next = PFB_SEL;
        end
      end
      PFB_SEL: begin
        if (write_reg) begin
          cnt_next   = CNT_W'(ACC_CYC); // RQ12
          state_next = PFB_WR;
        end else begin
          cnt_next   = CNT_W'(RC_CYC); // RQ12
          state_next = PFB_RD;
        end
      end
      PFB_RD: begin
        if (cnt_zero) begin
          cnt_next   = CNT_W'(PC_CYC); // RQ17
          state_next = PFB_PCHG;
        end
      end
      PFB_WR: begin
        if (cnt_zero) begin
          cnt_next   = CNT_W'(PC_CYC); // RQ17
          state_next = PFB_PCHG;
        end
      end
      PFB_PCHG: begin
        if (cnt_zero) begin // RQ17
          rdy_next   = 1'b1;
          state_next = PFB_IDLE;
        end
      end
      default: begin
        state_next = PFB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= PFB_IDLE;
      cnt_reg   <= '0;
      write_reg <= 1'b0;
      rdy_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      write_reg <= write_next;
      rdy_reg   <= rdy_next;
    end
  end

  // Request capture and read answer
  always_comb begin
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    rv_next    = 1'b0;
    if (state_reg == PFB_IDLE && take) begin
      addr_next  = req_addr; // RQ1 RQ6
      wdata_next = req_wdata; // RQ2
    end
    if (state_reg == PFB_RD && cnt_zero) begin
      rdata_next = data_bus_i; // RQ12
      rv_next    = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      addr_reg  <= '0;
      wdata_reg <= '0;
      rdata_reg <= '0;
      rv_reg    <= 1'b0;
    end else begin
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      rv_reg    <= rv_next;
    end
  end

  // Memory control pins
  always_comb begin
    sel_n_next = sel_n_reg;
    sel_p_next = 1'b1; // RQ7
    we_n_next  = we_n_reg;
    oe_n_next  = oe_n_reg;
    doe_n_next = doe_n_reg;
    unique case (state_reg)
      PFB_IDLE: begin
      end
      PFB_SEL: begin
        // Address settled one cycle, now select the device
        sel_n_next = 1'b0; // RQ5 RQ11
        if (write_reg) begin
          we_n_next  = 1'b0; // RQ3 RQ4
          oe_n_next  = 1'b1; // RQ18
          doe_n_next = 1'b0; // RQ2
        end else begin
          oe_n_next  = 1'b0; // RQ9
          doe_n_next = 1'b1; // RQ10
        end
      end
      PFB_RD: begin
        if (cnt_zero) begin
          oe_n_next  = 1'b1;
          // Deselect between accesses, so no page access is issued
          sel_n_next = 1'b1; // RQ8
        end
      end
      PFB_WR: begin
        if (cnt_zero) begin
          we_n_next  = 1'b1; // RQ3
          sel_n_next = 1'b1; // RQ8
        end
      end
      PFB_PCHG: begin
        // Data held through strobe rise, then released
        doe_n_next = 1'b1;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sel_n_reg <= 1'b1;
      sel_p_reg <= 1'b1;
      we_n_reg  <= 1'b1;
      oe_n_reg  <= 1'b1;
      doe_n_reg <= 1'b1;
    end else begin
      sel_n_reg <= sel_n_next;
      sel_p_reg <= sel_p_next;
      we_n_reg  <= we_n_next;
      oe_n_reg  <= oe_n_next;
      doe_n_reg <= doe_n_next;
    end
  end

  assign byte_address  = addr_reg;
  assign select_n      = sel_n_reg;
  assign select_p      = sel_p_reg;
  assign write_n       = we_n_reg;
  assign out_en_n      = oe_n_reg;
  assign data_bus_o    = wdata_reg;
  assign data_bus_oe_n = doe_n_reg;
  assign req_ready     = rdy_reg;
  assign rsp_valid     = rv_reg;
  assign rsp_rdata     = rdata_reg;
endmodule : pfb_host
`default_nettype wire

// ---- testbench/pfb_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
module pfb_mem (
  input  wire logic [16:0] byte_address,
  input  wire logic        select_n,
  input  wire logic        select_p,
  input  wire logic        write_n,
  input  wire logic        out_en_n,
  input  wire logic [7:0]  data_bus,
  output logic [7:0]       rd_data,
  output logic             rd_drive
);
  logic [7:0]  mem [0:131071];
  logic [16:0] lat;
  logic [7:0]  wd;
  logic        done = 1'b0;
  logic        wr = 1'b0;
  // Undriven select_p reads as high
  wire         sel = !select_n && (select_p !== 1'b0);
  always @(select_n or select_p or byte_address) begin
    done = 1'b0;
    if (sel) begin
      lat = byte_address;
      #60 done = sel;
    end
  end
  always @(negedge write_n) if (sel) lat[2:0] = byte_address[2:0];
  always @(data_bus or write_n) if (!write_n && sel) begin
    wd = data_bus;
    wr = 1'b1;
  end
  always @(posedge write_n or posedge select_n) if (wr) begin
    mem[lat] = wd;
    wr = 1'b0;
  end
  assign rd_data = mem[lat];
  assign rd_drive = sel && done && !out_en_n && write_n;
endmodule : pfb_mem
`default_nettype wire

// ---- testbench/pfb_host_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module pfb_host_chk (
  input wire logic        clk, rst, select_n, select_p, write_n, out_en_n,
  input wire logic        data_bus_oe_n, rsp_valid,
  input wire logic [16:0] byte_address
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_bus_turn: assert property (!data_bus_oe_n |-> out_en_n)
    else $error("host drives bus during read");
  a_strobe_data: assert property (!write_n |-> !data_bus_oe_n)
    else $error("write strobe without data");
  a_strobe_sel: assert property (!write_n |-> !select_n)
    else $error("write strobe while deselected");
  a_sel_high: assert property (select_p)
    else $error("select_p low");
  a_addr_hold: assert property (!select_n && $past(!select_n) |-> $stable(byte_address))
    else $error("address moved while selected");
  a_cycle_min: assert property ($fell(select_n) |-> !select_n [*3])
    else $error("select shorter than cycle time");
  a_pchg_min: assert property ($rose(select_n) |-> select_n [*2])
    else $error("precharge too short");
  a_read_time: assert property ($fell(select_n) && !out_en_n |-> ##[2:6] rsp_valid)
    else $error("read answer late");
endmodule : pfb_host_chk
bind pfb_host pfb_host_chk u_chk (.clk(clk), .rst(rst), .select_n(select_n),
  .select_p(select_p), .write_n(write_n), .out_en_n(out_en_n), .rsp_valid(rsp_valid),
  .data_bus_oe_n(data_bus_oe_n), .byte_address(byte_address));
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pfb_pkg::*;
  logic              clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0;
  logic              req_ready, rsp_valid, select_n, select_p, write_n, out_en_n;
  logic              data_bus_oe_n, rd_drive;
  logic [ADDR_W-1:0] req_addr = '0, byte_address;
  logic [DATA_W-1:0] req_wdata = '0, rsp_rdata, data_bus_o, rd_data, bus;
  int                n_mismatch = 0, check_count = 0;
  logic [25:0]       rows [6] = '{{1'b1, 17'h0_0000, 8'hA5}, {1'b1, 17'h1_FFFF, 8'h3C},
    {1'b1, 17'h0_0007, 8'hC3}, {1'b0, 17'h1_FFFF, 8'h3C}, {1'b0, 17'h0_0000, 8'hA5},
    {1'b0, 17'h0_0007, 8'hC3}};
  // Released bus shows the inverse of the last host data
  assign bus = !data_bus_oe_n ? data_bus_o : rd_drive ? rd_data : ~data_bus_o;
  pfb_host u_pfb_host (.clk(clk), .rst(rst), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .byte_address(byte_address),
    .select_n(select_n), .select_p(select_p), .write_n(write_n), .out_en_n(out_en_n),
    .data_bus_i(bus), .data_bus_o(data_bus_o), .data_bus_oe_n(data_bus_oe_n));
  pfb_mem u_pfb_mem (.byte_address(byte_address), .select_n(select_n),
    .select_p(select_p), .write_n(write_n), .out_en_n(out_en_n), .data_bus(bus),
    .rd_data(rd_data), .rd_drive(rd_drive));
  initial forever #20 clk = ~clk;
  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task acc(input logic [25:0] r);
    int i;
    repeat (2) @(negedge clk);
    for (i = 0; i < 40 && req_ready !== 1'b1; i++) @(negedge clk);
    if (req_ready !== 1'b1) begin
      n_mismatch++;
      end_of_test;
    end
    @(posedge clk);
    {req_write, req_addr, req_wdata} <= r;
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    if (!r[25]) begin
      for (i = 0; i < 20 && rsp_valid !== 1'b1; i++) @(negedge clk);
      if (rsp_valid !== 1'b1) begin
        n_mismatch++;
        end_of_test;
      end
      chk("rsp_rdata", r[7:0], rsp_rdata);
    end
  endtask : acc
  initial begin
    repeat (5) @(negedge clk);
    chk("idle pins", 8'h0F, {4'h0, select_n, write_n, out_en_n, data_bus_oe_n});
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[k]) acc(rows[k]);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("reset pins", 8'h0F, {4'h0, select_n, write_n, out_en_n, data_bus_oe_n});
    rst <= 1'b0;
    acc({1'b0, 17'h0_0000, 8'hA5});
    acc({1'b0, 17'h1_FFFF, 8'h3C});
    end_of_test;
  end
  initial begin
    #200us;
    n_mismatch++;
    end_of_test;
  end
endmodule : testbench
`default_nettype wire
